// ---- design/tcr_config_regs.sv ----
// Configuration register bank of a pressure transmitter, with its link,
// temperature-timing and pressure low-pass logic.
// Assumes a holding-register request port driven synchronously to clk.
`timescale 1ns/1ns
`default_nettype none
module tcr_config_regs
    import tcr_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int SEC_CYCLES = SECOND_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    output logic ack,
    output logic err,
    output logic [15:0] rdata,
    input wire logic factory_mode,
    input wire logic device_restart,
    input wire logic [15:0] factory_filter,
    input wire logic [31:0] serial_number,
    input wire logic [1:0] pressure_active,
    input wire logic [3:0] temperature_active,
    output tcr_link_t link_cfg,
    output logic [15:0] bit_cycles,
    output logic [7:0] calculated_channel,
    output logic temp_measure,
    output logic temp_compensate,
    input wire logic sample_valid,
    input wire logic signed [SAMPLE_W-1:0] first_pressure,
    input wire logic signed [SAMPLE_W-1:0] second_pressure,
    output logic filtered_valid,
    output logic signed [SAMPLE_W-1:0] first_filtered,
    output logic signed [SAMPLE_W-1:0] second_filtered
);
    // ==========================================================
    // Register storage and helpers
    logic [7:0] calc_sel;
    logic [15:0] temp_measure_interval;
    logic [3:0] temp_comp_multiplier;
    logic [3:0] pressure_lowpass_exponent;
    logic loaded;
    logic wr_hit;
    logic [7:0] press_map;
    logic [7:0] temp_map;

    function automatic logic sel_legal(input logic [7:0] code, input logic fac,
                                       input logic p2_on);
        logic ok;
        ok = (code <= 8'h06) || (code == 8'h0b) || (code == 8'h0c) || (code == 8'h0f);
        if (code == SEL_FACTORY_ONLY) begin
            ok = fac;
        end
        if (code == SEL_LINEAR_FIT) begin
            ok = !p2_on;
        end
        return ok;
    endfunction

    assign wr_hit = req && we;
    assign press_map = {5'h00, pressure_active, 1'b0};
    assign temp_map = {temperature_active[3], 1'b0, temperature_active[2:0], 3'h0};

    // ==========================================================
    // Writable registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link_cfg <= '0;
        end else if (wr_hit && addr == ADDR_LINK) begin
            link_cfg.baud <= wdata[BAUD_LSB +: 4];
            link_cfg.parity_en <= wdata[PARITY_EN_BIT];
            link_cfg.parity_even <= wdata[PARITY_EVEN_BIT];
            link_cfg.two_stop <= wdata[TWO_STOP_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cycles <= BIT_CYCLES_LOW;
        end else if (link_cfg.baud == BAUD_CODE_115200) begin
            bit_cycles <= BIT_CYCLES_HIGH;
        end else begin
            bit_cycles <= BIT_CYCLES_LOW;
        end
    end

    // Undefined or disallowed selector codes are dropped so the stored code is usable in the modes present at its write.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            calc_sel <= RST_CALC_SEL;
        end else if (wr_hit && addr == ADDR_CALC_SEL &&
                     sel_legal(wdata[7:0], factory_mode, pressure_active[1])) begin
            calc_sel <= wdata[7:0];
        end
    end

    // The running selection changes only on a restart, as the master expects.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loaded <= 1'b0;
            calculated_channel <= RST_CALC_SEL;
        end else begin
            loaded <= 1'b1;
            if (!loaded || device_restart) begin
                calculated_channel <= calc_sel;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_measure_interval <= RST_TEMP_IVL;
            temp_comp_multiplier <= RST_TCOMP_MULT;
            pressure_lowpass_exponent <= RST_LP_EXP;
        end else if (wr_hit && addr == ADDR_TEMP_IVL) begin
            temp_measure_interval <= wdata;
        end else if (wr_hit && addr == ADDR_TCOMP_LP) begin
            temp_comp_multiplier <= wdata[3:0];
            pressure_lowpass_exponent <= wdata[7:4];
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
            err <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            ack <= req;
            err <= 1'b0;
            rdata <= 16'h0000;
            if (req) begin
                unique case (addr)
                    // The struct holds baud on top, so the word is rebuilt in bit order.
                    ADDR_LINK: rdata <= {9'h000, link_cfg.two_stop, link_cfg.parity_even,
                                         link_cfg.parity_en, link_cfg.baud};
                    ADDR_FILT_BACKUP: rdata <= factory_filter;
                    ADDR_SN_HIGH: rdata <= serial_number[31:16];
                    ADDR_SN_LOW: rdata <= serial_number[15:0];
                    ADDR_PRESS_ACT: rdata <= {8'h00, press_map};
                    ADDR_TEMP_ACT: rdata <= {8'h00, temp_map};
                    ADDR_CALC_SEL: rdata <= {8'h00, calc_sel};
                    ADDR_TEMP_IVL: rdata <= temp_measure_interval;
                    ADDR_TCOMP_LP: rdata <= {8'h00, pressure_lowpass_exponent,
                                             temp_comp_multiplier};
                    default: err <= 1'b1;
                endcase
            end
        end
    end

    // ==========================================================
    // Temperature timing
    localparam int SEC_W = $clog2(SEC_CYCLES + 1);
    localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);
    tcr_timer_t timer_state;
    logic [SEC_W-1:0] sec_count;
    logic [15:0] sec_in_ivl;
    logic [3:0] meas_count;
    logic sec_tick;

    // A zero interval masks the tick, so no pulse slips out while the timer winds down.
    assign sec_tick = (timer_state == TCR_RUN) && (sec_count == SEC_LAST) &&
                      (temp_measure_interval != 16'h0000);

    // A zero interval stops measurements rather than firing on every second.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_state <= TCR_IDLE;
            sec_count <= '0;
        end else begin
            unique case (timer_state)
                TCR_IDLE: begin
                    sec_count <= '0;
                    if (temp_measure_interval != 16'h0000) begin
                        timer_state <= TCR_RUN;
                    end
                end
                TCR_RUN: begin
                    if (temp_measure_interval == 16'h0000) begin
                        timer_state <= TCR_IDLE;
                    end
                    sec_count <= sec_tick ? '0 : sec_count + SEC_W'(1);
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sec_in_ivl <= 16'h0000;
            meas_count <= 4'h0;
            temp_measure <= 1'b0;
            temp_compensate <= 1'b0;
        end else begin
            temp_measure <= 1'b0;
            temp_compensate <= 1'b0;
            if (timer_state == TCR_IDLE) begin
                sec_in_ivl <= 16'h0000;
            end else if (sec_tick) begin
                if (sec_in_ivl + 16'h0001 >= temp_measure_interval) begin
                    sec_in_ivl <= 16'h0000;
                    temp_measure <= 1'b1;
                    if (temp_comp_multiplier != 4'h0 &&
                        meas_count + 4'h1 >= temp_comp_multiplier) begin
                        meas_count <= 4'h0;
                        temp_compensate <= 1'b1;
                    end else begin
                        meas_count <= meas_count + 4'h1;
                    end
                end else begin
                    sec_in_ivl <= sec_in_ivl + 16'h0001;
                end
            end
        end
    end

    // ==========================================================
    // Pressure low-pass filter
    localparam int ACC_W = SAMPLE_W + 17;
    logic signed [SAMPLE_W-1:0] filt [2];
    logic signed [SAMPLE_W-1:0] next_filt [2];
    logic signed [SAMPLE_W-1:0] sample [2];

    assign sample[0] = first_pressure;
    assign sample[1] = second_pressure;

    // The sum is widened so no exponent up to fifteen can overflow it.
    for (genvar ch = 0; ch < 2; ch++) begin : g_lp
        always_comb begin
            logic signed [ACC_W-1:0] old_x;
            logic signed [ACC_W-1:0] acc;
            old_x = ACC_W'(filt[ch]);
            acc = (old_x <<< pressure_lowpass_exponent) - old_x + ACC_W'(sample[ch]);
            next_filt[ch] = SAMPLE_W'(acc >>> pressure_lowpass_exponent);
        end
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                filt[ch] <= '0;
            end else if (sample_valid) begin
                filt[ch] <= next_filt[ch];
            end
        end
    end

    assign first_filtered = filt[0];
    assign second_filtered = filt[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filtered_valid <= 1'b0;
        end else begin
            filtered_valid <= sample_valid;
        end
    end

    // ==========================================================
    // Checks
    a_read_answer: assert property (@(posedge clk) disable iff (!arst_n)
        req |=> ack && (rdata[15:8] == 8'h00 || $past(addr) == ADDR_FILT_BACKUP ||
                        $past(addr) == ADDR_SN_HIGH || $past(addr) == ADDR_SN_LOW ||
                        $past(addr) == ADDR_TEMP_IVL))
        else $error("Read answer late or upper byte not zero.");
    a_baud_select: assert property (@(posedge clk) disable iff (!arst_n)
        link_cfg.baud == BAUD_CODE_115200 |=> bit_cycles == BIT_CYCLES_HIGH)
        else $error("Fast baud code did not set the fast bit period.");
    a_link_fields: assert property (@(posedge clk) disable iff (!arst_n)
        wr_hit && addr == ADDR_LINK |=> link_cfg.parity_en == $past(wdata[4]) &&
            link_cfg.parity_even == $past(wdata[5]) && link_cfg.two_stop == $past(wdata[6]))
        else $error("Link settings not taken from the written word.");
    a_serial_order: assert property (@(posedge clk) disable iff (!arst_n)
        req && !we && addr == ADDR_SN_HIGH |=> rdata == $past(serial_number[31:16]))
        else $error("Serial number high half misplaced.");
    a_factory_code: assert property (@(posedge clk) disable iff (!arst_n)
        wr_hit && addr == ADDR_CALC_SEL && wdata[7:0] == SEL_FACTORY_ONLY && !factory_mode
        |=> $stable(calc_sel))
        else $error("Factory-only selector accepted outside the factory.");
    a_fit_code: assert property (@(posedge clk) disable iff (!arst_n)
        wr_hit && addr == ADDR_CALC_SEL && wdata[7:0] == SEL_LINEAR_FIT && pressure_active[1]
        |=> $stable(calc_sel))
        else $error("Line fit accepted with second pressure active.");
    a_restart_only: assert property (@(posedge clk) disable iff (!arst_n)
        loaded && !device_restart |=> $stable(calculated_channel))
        else $error("Running selection changed without a restart.");
    a_measure_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        temp_compensate |-> temp_measure ##1 !temp_measure [*2])
        else $error("Compensation without measurement or pulse too long.");
    a_filter_step: assert property (@(posedge clk) disable iff (!arst_n)
        sample_valid && pressure_lowpass_exponent == 4'h0 |=> first_filtered == $past(first_pressure))
        else $error("Unity filter did not pass the sample.");
    a_ro_ignored: assert property (@(posedge clk) disable iff (!arst_n)
        req && we && addr == ADDR_PRESS_ACT |=> $stable(calc_sel) && $stable(link_cfg))
        else $error("Write to a read-only register disturbed state.");
    a_unmapped_err: assert property (@(posedge clk) disable iff (!arst_n)
        req && (addr < ADDR_LINK || addr > ADDR_TCOMP_LP) |=> err && rdata == 16'h0000)
        else $error("Unmapped address not refused with a zero word.");
    a_baud_slow: assert property (@(posedge clk) disable iff (!arst_n)
        link_cfg.baud != BAUD_CODE_115200 |=> bit_cycles == BIT_CYCLES_LOW)
        else $error("Slow baud code did not set the slow bit period.");
    a_backup_read: assert property (@(posedge clk) disable iff (!arst_n)
        req && addr == ADDR_FILT_BACKUP |=> rdata == $past(factory_filter))
        else $error("Factory filter backup not returned.");
    a_serial_low: assert property (@(posedge clk) disable iff (!arst_n)
        req && addr == ADDR_SN_LOW |=> rdata == $past(serial_number[15:0]))
        else $error("Serial number low half misplaced.");
    a_press_map: assert property (@(posedge clk) disable iff (!arst_n)
        req && addr == ADDR_PRESS_ACT |=> rdata == {13'h0, $past(pressure_active), 1'b0})
        else $error("Pressure channel map bits misplaced.");
    a_sel_range: assert property (@(posedge clk) disable iff (!arst_n)
        wr_hit && addr == ADDR_CALC_SEL && wdata[7:0] > 8'h0f |=> $stable(calc_sel))
        else $error("Undefined selector code accepted.");
    a_interval_zero: assert property (@(posedge clk) disable iff (!arst_n)
        temp_measure_interval == 16'h0000 |=> !temp_measure)
        else $error("Measurement pulse with a zero interval.");
    a_filter_valid: assert property (@(posedge clk) disable iff (!arst_n)
        sample_valid |=> filtered_valid)
        else $error("Filtered result not flagged after a sample.");
endmodule
`default_nettype wire

// ---- include/tcr_pkg.sv ----
// Package for the transmitter configuration register bank.
// Assumes a single 20 MHz clock domain and a 16-bit holding-register port.
package tcr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [15:0] ADDR_LINK = 16'h0200;
    localparam logic [15:0] ADDR_FILT_BACKUP = 16'h0201;
    localparam logic [15:0] ADDR_SN_HIGH = 16'h0202;
    localparam logic [15:0] ADDR_SN_LOW = 16'h0203;
    localparam logic [15:0] ADDR_PRESS_ACT = 16'h0204;
    localparam logic [15:0] ADDR_TEMP_ACT = 16'h0205;
    localparam logic [15:0] ADDR_CALC_SEL = 16'h0206;
    localparam logic [15:0] ADDR_TEMP_IVL = 16'h0207;
    localparam logic [15:0] ADDR_TCOMP_LP = 16'h0208;
    // ==========================================================
    // Field positions
    localparam int BAUD_LSB = 0;
    localparam int PARITY_EN_BIT = 4;
    localparam int PARITY_EVEN_BIT = 5;
    localparam int TWO_STOP_BIT = 6;
    localparam int P1_ACT_BIT = 1;
    localparam int P2_ACT_BIT = 2;
    localparam int T_ACT_BIT = 3;
    localparam int FIRST_SENSOR_TEMPERATURE_ACT_BIT = 4;
    localparam int SECOND_SENSOR_TEMPERATURE_ACT_BIT = 5;
    localparam int CON_ACT_BIT = 7;
    localparam logic [7:0] PRESS_ACT_MASK = 8'h06;
    localparam logic [7:0] TEMP_ACT_MASK = 8'hb8;
    // ==========================================================
    // Codes and reset values
    localparam logic [3:0] BAUD_CODE_9600 = 4'h0;
    localparam logic [3:0] BAUD_CODE_115200 = 4'h1;
    localparam logic [7:0] SEL_FACTORY_ONLY = 8'h0d;
    localparam logic [7:0] SEL_LINEAR_FIT = 8'h0e;
    localparam logic [7:0] RST_CALC_SEL = 8'h00;
    localparam logic [15:0] RST_TEMP_IVL = 16'h000a;
    localparam logic [3:0] RST_TCOMP_MULT = 4'h1;
    localparam logic [3:0] RST_LP_EXP = 4'h0;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_LOW = 9600;
    localparam int BAUD_HIGH = 115200;
    localparam logic [15:0] BIT_CYCLES_LOW = 16'(CLK_HZ / BAUD_LOW);
    localparam logic [15:0] BIT_CYCLES_HIGH = 16'(CLK_HZ / BAUD_HIGH);
    localparam int SECOND_CYCLES = CLK_HZ;

    typedef struct packed {
        logic [3:0] baud;
        logic parity_en;
        logic parity_even;
        logic two_stop;
    } tcr_link_t;

    typedef enum logic [1:0] {
        TCR_IDLE = 2'b00,
        TCR_RUN = 2'b01
    } tcr_timer_t;
endpackage

// ---- sim/tcr_master.sv ----
// Register master model that stands on the far side of the configuration bank.
// Assumes the bank answers on the same edge that takes a request pulse.
`timescale 1ns/1ns
`default_nettype none
module tcr_master (
    input wire logic clk,
    output logic req,
    output logic we,
    output logic [15:0] addr,
    output logic [15:0] wdata,
    output logic device_restart,
    input wire logic ack,
    input wire logic err,
    input wire logic [15:0] rdata
);
    // ==========================================================
    // Idle levels
    initial begin
        req = 1'b0;
        we = 1'b0;
        addr = 16'hffff;
        wdata = 16'hffff;
        device_restart = 1'b0;
    end

    // ==========================================================
    // One request pulse, answer taken once the answering edge has landed.
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
            output logic [15:0] rd, output logic e, output logic k);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        // Released lines show the inverse, so a stale value never looks held.
        addr <= ~a;
        wdata <= ~d;
        #1;
        k = ack;
        rd = rdata;
        e = err;
    endtask

    // ==========================================================
    // A new selector is only put to use after this restart pulse.
    task automatic restart();
        @(posedge clk);
        device_restart <= 1'b1;
        @(posedge clk);
        device_restart <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking testbench for the transmitter configuration register bank.
// Assumes the bank package and a shortened second of ten clocks.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import tcr_pkg::*;
    logic clk, arst_n, req, we, ack, err, factory_mode, device_restart, sample_valid;
    logic [15:0] addr, wdata, rdata, factory_filter, bit_cycles;
    logic [31:0] serial_number;
    logic [1:0] pressure_active;
    logic [3:0] temperature_active;
    logic [7:0] calculated_channel;
    logic temp_measure, temp_compensate, filtered_valid;
    logic signed [23:0] first_pressure, second_pressure, first_filtered, second_filtered;
    tcr_link_t link_cfg;
    int err_total = 0;
    int num_checks = 0;

    // ==========================================================
    // Instances
    tcr_config_regs #(.SAMPLE_W(24), .SEC_CYCLES(10)) dut (.clk(clk), .arst_n(arst_n),
        .req(req), .we(we), .addr(addr), .wdata(wdata), .ack(ack), .err(err),
        .rdata(rdata), .factory_mode(factory_mode), .device_restart(device_restart),
        .factory_filter(factory_filter), .serial_number(serial_number),
        .pressure_active(pressure_active), .temperature_active(temperature_active),
        .link_cfg(link_cfg), .bit_cycles(bit_cycles), .calculated_channel(calculated_channel),
        .temp_measure(temp_measure), .temp_compensate(temp_compensate),
        .sample_valid(sample_valid), .first_pressure(first_pressure),
        .second_pressure(second_pressure), .filtered_valid(filtered_valid),
        .first_filtered(first_filtered), .second_filtered(second_filtered));
    tcr_master u_mst (.clk(clk), .req(req), .we(we), .addr(addr), .wdata(wdata),
        .device_restart(device_restart), .ack(ack), .err(err), .rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // Shared access and closing
    task automatic rr(input logic [15:0] a, input logic [15:0] wd, input logic w,
            input logic xe, output logic [15:0] d);
        logic e, k;
        u_mst.access(w, a, wd, d, e, k);
        `CHK("ack", 1'b1, k)
        `CHK("err", xe, e)
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [15:0] d;
        `CHK("bit_cycles", BIT_CYCLES_LOW, bit_cycles)
        rr(ADDR_TEMP_IVL, 16'h0, 1'b0, 1'b0, d);
        `CHK("interval", RST_TEMP_IVL, d)
        rr(ADDR_TCOMP_LP, 16'h0, 1'b0, 1'b0, d);
        `CHK("tcomp", {8'h00, RST_LP_EXP, RST_TCOMP_MULT}, d)
        rr(16'h0209, 16'h0, 1'b0, 1'b1, d);
        `CHK("unmapped", 16'h0000, d)
        rr(16'h01ff, 16'h1234, 1'b1, 1'b1, d);
    endtask

    task automatic t_link();
        logic [15:0] v [4] = '{16'h0071, 16'hff80, 16'h0041, 16'h001f};
        logic [15:0] d;
        logic [15:0] xb;
        foreach (v[i]) begin
            rr(ADDR_LINK, v[i], 1'b1, 1'b0, d);
            rr(ADDR_LINK, 16'h0, 1'b0, 1'b0, d);
            xb = (v[i][3:0] == BAUD_CODE_115200) ? BIT_CYCLES_HIGH : BIT_CYCLES_LOW;
            `CHK("link_rd", v[i] & 16'h007f, d)
            `CHK("link_cfg", {v[i][3:0], v[i][4], v[i][5], v[i][6]}, link_cfg)
            `CHK("bit_cycles", xb, bit_cycles)
        end
    endtask

    task automatic t_ro();
        logic [15:0] d;
        logic [1:0] pa;
        logic [3:0] ta;
        for (int j = 0; j < 2; j++) begin
            pa = j ? 2'b01 : 2'b10;
            ta = j ? 4'b0101 : 4'b1010;
            @(posedge clk);
            serial_number <= j ? 32'h1234_abcd : 32'hfedc_0123;
            factory_filter <= j ? 16'h5a3c : 16'hc3a5;
            pressure_active <= pa;
            temperature_active <= ta;
            for (int i = 1; i < 6; i++) rr(ADDR_LINK + 16'(i), 16'hffff, 1'b1, 1'b0, d);
            rr(ADDR_FILT_BACKUP, 16'h0, 1'b0, 1'b0, d);
            `CHK("filt_bck", j ? 16'h5a3c : 16'hc3a5, d)
            rr(ADDR_SN_HIGH, 16'h0, 1'b0, 1'b0, d);
            `CHK("sn_high", j ? 16'h1234 : 16'hfedc, d)
            rr(ADDR_SN_LOW, 16'h0, 1'b0, 1'b0, d);
            `CHK("sn_low", j ? 16'habcd : 16'h0123, d)
            rr(ADDR_PRESS_ACT, 16'h0, 1'b0, 1'b0, d);
            `CHK("press_act", {13'h0, pa, 1'b0}, d)
            rr(ADDR_TEMP_ACT, 16'h0, 1'b0, 1'b0, d);
            `CHK("temp_act", {8'h0, ta[3], 1'b0, ta[2:0], 3'b0}, d)
        end
    endtask

    task automatic t_sel();
        logic [15:0] d;
        logic [7:0] xs;
        xs = 8'h00;
        @(posedge clk);
        factory_mode <= 1'b0;
        pressure_active <= 2'b11;
        for (int c = 0; c < 18; c++) begin
            rr(ADDR_CALC_SEL, 16'(c), 1'b1, 1'b0, d);
            if (c <= 6 || c == 11 || c == 12 || c == 15) xs = 8'(c);
            rr(ADDR_CALC_SEL, 16'h0, 1'b0, 1'b0, d);
            `CHK("sel_rd", {8'h00, xs}, d)
        end
        `CHK("calc_before", 8'h00, calculated_channel)
        u_mst.restart();
        `CHK("calc_after", xs, calculated_channel)
        @(posedge clk);
        factory_mode <= 1'b1;
        rr(ADDR_CALC_SEL, 16'h000d, 1'b1, 1'b0, d);
        rr(ADDR_CALC_SEL, 16'h0, 1'b0, 1'b0, d);
        `CHK("sel_factory", 16'h000d, d)
        @(posedge clk);
        pressure_active <= 2'b01;
        rr(ADDR_CALC_SEL, 16'h000e, 1'b1, 1'b0, d);
        u_mst.restart();
        `CHK("calc_fit", 8'h0e, calculated_channel)
    endtask

    task automatic t_timer();
        logic [15:0] d;
        int tm, tc, nm, nc;
        tm = -1;
        tc = -1;
        nm = 0;
        nc = 0;
        rr(ADDR_TCOMP_LP, 16'h0002, 1'b1, 1'b0, d);
        rr(ADDR_TEMP_IVL, 16'h0003, 1'b1, 1'b0, d);
        for (int t = 0; t < 200; t++) begin
            @(posedge clk);
            #1;
            if (temp_compensate === 1'b1) begin
                `CHK("comp_meas", 1'b1, temp_measure)
                if (tc >= 0) `CHK("comp_gap", 60, t - tc)
                tc = t;
                nc++;
            end
            if (temp_measure === 1'b1) begin
                if (tm >= 0) `CHK("meas_gap", 30, t - tm)
                tm = t;
                nm++;
            end
        end
        `CHK("meas_cnt", 1'b1, nm >= 6 && nc >= 2)
        rr(ADDR_TEMP_IVL, 16'h0000, 1'b1, 1'b0, d);
        nm = 0;
        repeat (80) begin
            @(posedge clk);
            #1;
            if (temp_measure !== 1'b0) nm++;
        end
        `CHK("meas_stop", 0, nm)
    endtask

    task automatic fsend(input logic signed [23:0] s, input logic signed [23:0] e1,
            input logic signed [23:0] e2);
        @(posedge clk);
        sample_valid <= 1'b1;
        first_pressure <= s;
        second_pressure <= -s;
        @(posedge clk);
        sample_valid <= 1'b0;
        #1;
        `CHK("filt_valid", 1'b1, filtered_valid)
        `CHK("first_filt", e1, first_filtered)
        `CHK("second_filt", e2, second_filtered)
    endtask

    task automatic t_filt();
        logic signed [23:0] s [4] = '{24'sd100, -24'sd40, 24'sd7, 24'sd1000};
        logic signed [23:0] m1, m2;
        logic [15:0] d;
        m1 = 24'sd0;
        m2 = 24'sd0;
        rr(ADDR_TCOMP_LP, 16'h0020, 1'b1, 1'b0, d);
        foreach (s[i]) begin
            m1 = ((m1 <<< 2) - m1 + s[i]) >>> 2;
            m2 = ((m2 <<< 2) - m2 - s[i]) >>> 2;
            fsend(s[i], m1, m2);
        end
        rr(ADDR_TCOMP_LP, 16'h0000, 1'b1, 1'b0, d);
        fsend(24'sd555, 24'sd555, -24'sd555);
    endtask

    // A reset in mid-run must bring back the link, bit period, interval and filter values and the running selection.
    task automatic t_rst2();
        logic [15:0] d;
        rr(ADDR_LINK, 16'h0041, 1'b1, 1'b0, d);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        `CHK("rst_link", 7'h00, link_cfg)
        `CHK("rst_bits", BIT_CYCLES_LOW, bit_cycles)
        `CHK("rst_filt", 24'sd0, first_filtered)
        rr(ADDR_TEMP_IVL, 16'h0, 1'b0, 1'b0, d);
        `CHK("rst_ivl", RST_TEMP_IVL, d)
        `CHK("rst_calc", 8'h00, calculated_channel)
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        arst_n = 1'b0;
        factory_mode = 1'b0;
        sample_valid = 1'b0;
        factory_filter = 16'h0;
        serial_number = 32'h0;
        pressure_active = 2'b00;
        temperature_active = 4'h0;
        first_pressure = 24'sd0;
        second_pressure = 24'sd0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_link();
        t_ro();
        t_sel();
        t_timer();
        t_filt();
        t_rst2();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
